// File: rtl/pfm_pkg.sv
// Operation
// RULE1 - Pins three and four hold a built-in role while the reset output is low, and afterwards the keep bit (bit 7) keeps the selected function at 1 or disables it at 0.
// RULE2 - Select codes 0000, 0001 and 0010 make the pin the first general output, the second general output and the active-low interrupt request output.
// RULE3 - Select codes 0011 to 0110 make the pin an input for sleep, deeper sleep, rail one and two enable, and power off requests.
// RULE4 - Codes 0111 and 1000 are the external enable inputs one and two, have no function on pins three and four, and software must not program them there.
// RULE5 - Pin five alone also accepts code 1001, the system monitor function.
// RULE6 - A general output drives the pin from the level field, 00 giving low and 01 giving high.
// RULE7 - An external enable output on pins three or four stays inactive until the reset output has gone high.
// RULE8 - The reset value of pin five's select comes from pin three's sensed level: high gives 0011, high impedance or low gives 0010.
// RULE9 - Before the reset output goes high, pins three and four choose the rail voltage selection.
// RULE10 - Host software raises an external enable output through the level field only after the reset output has gone high.
// RULE11 - Select codes above the valid range leave the pin inactive, driving nothing and ignoring its input, without disturbing other pins.
// RULE12 - Reserved bits, bit 2 of each register among them, read as zero and ignore writes.
`default_nettype none
package pfm_pkg;
   localparam int          PIN_COUNT  = 3;
   localparam int          PIN5_IDX   = 2;
   localparam logic [7:0]  ADDR_PIN3  = 8'h07;
   localparam logic [7:0]  ADDR_PIN4  = 8'h08;
   localparam logic [7:0]  ADDR_PIN5  = 8'h09;
   localparam int          KEEP_BIT   = 7;
   localparam int          SEL_HI     = 6;
   localparam int          SEL_LO     = 3;
   localparam int          LVL_HI     = 1;
   localparam int          LVL_LO     = 0;
   localparam logic [1:0]  LVL_LOW    = 2'h0;
   localparam logic [1:0]  LVL_HIGH   = 2'h1;
   localparam logic [1:0]  LVL_RESET  = 2'h0;
   localparam logic        KEEP_RESET = 1'h0;
   localparam logic [7:0]  RDATA_ZERO = 8'h00;
   localparam logic [1:0]  VSEL_RESET = 2'h0;

   typedef enum logic [3:0] {
      FUNC_GEN_OUT1  = 4'h0,
      FUNC_GEN_OUT2  = 4'h1,
      FUNC_IRQ_OUT   = 4'h2,
      FUNC_SLEEP     = 4'h3,
      FUNC_DEEP      = 4'h4,
      FUNC_RAIL12    = 4'h5,
      FUNC_POWER_OFF = 4'h6,
      FUNC_EXT_IN1   = 4'h7,
      FUNC_EXT_IN2   = 4'h8,
      FUNC_SYSTEM_MONITOR_FUNCTION    = 4'h9
   } pfm_func_t;

   localparam logic [3:0]  SEL_RESET       = 4'h0;
   localparam logic [3:0]  PIN5_SEL_LOW    = 4'h2;
   localparam logic [3:0]  PIN5_SEL_HIGH   = 4'h3;

   // index of each input function in the function vector
   localparam int FN_SLEEP     = 0;
   localparam int FN_DEEP      = 1;
   localparam int FN_RAIL12    = 2;
   localparam int FN_POWER_OFF = 3;
   localparam int FN_EXT_IN1   = 4;
   localparam int FN_EXT_IN2   = 5;
   localparam int FN_SYSTEM_MONITOR_FUNCTION    = 6;
   localparam int FN_COUNT     = 7;
endpackage
`default_nettype wire

// File: rtl/pfm_pin_slice.sv
`default_nettype none
module pfm_pin_slice
   import pfm_pkg::*;
#(
   parameter bit HAS_KEEP    = 1'b1,
   parameter bit HAS_MONITOR = 1'b0
) (
   input  wire logic [3:0]          sel,
   input  wire logic [1:0]          level,
   input  wire logic                keep,
   input  wire logic                reset_out_high,
   input  wire logic                pad_in,
   input  wire logic                irq_low,
   output logic                     drive_en,
   output logic                     drive_level,
   output logic [FN_COUNT-1:0]      func_in,
   output logic                     vsel_role
);
   wire logic active;
   wire logic lvl_high;
   wire logic is_gen;
   wire logic is_irq;
   wire logic ext_ok;

   // pins with a keep bit stay in their built-in role until release
   assign active    = HAS_KEEP ? (reset_out_high & keep) : 1'b1; // RULE1 RULE7
   assign vsel_role = HAS_KEEP & ~reset_out_high; // RULE9
   assign lvl_high  = (level == LVL_HIGH); // RULE6
   assign is_gen    = active & ((sel == FUNC_GEN_OUT1) |
                                (sel == FUNC_GEN_OUT2)); // RULE2
   assign is_irq    = active & (sel == FUNC_IRQ_OUT); // RULE2
   assign ext_ok    = active & ~HAS_KEEP; // RULE4
   // codes above the range match nothing and leave the pin idle
   assign drive_en    = is_gen | is_irq; // RULE11
   assign drive_level = is_irq ? irq_low : (is_gen & lvl_high); // RULE6

   assign func_in[FN_SLEEP]     = active & pad_in & (sel == FUNC_SLEEP); // RULE3
   assign func_in[FN_DEEP]      = active & pad_in & (sel == FUNC_DEEP); // RULE3
   assign func_in[FN_RAIL12]    = active & pad_in & (sel == FUNC_RAIL12); // RULE3
   assign func_in[FN_POWER_OFF] = active & pad_in &
                                  (sel == FUNC_POWER_OFF); // RULE3
   assign func_in[FN_EXT_IN1]   = ext_ok & pad_in & (sel == FUNC_EXT_IN1); // RULE4
   assign func_in[FN_EXT_IN2]   = ext_ok & pad_in & (sel == FUNC_EXT_IN2); // RULE4
   assign func_in[FN_SYSTEM_MONITOR_FUNCTION]    = active & HAS_MONITOR & pad_in &
                                  (sel == FUNC_SYSTEM_MONITOR_FUNCTION); // RULE5
endmodule
`default_nettype wire

// File: rtl/pfm_top.sv
`default_nettype none
module pfm_top
   import pfm_pkg::*;
(
   input  wire logic                  ref_clk,
   input  wire logic                  arst_n,
   input  wire logic                  reg_wr_en,
   input  wire logic                  reg_rd_en,
   input  wire logic [7:0]            reg_addr,
   input  wire logic [7:0]            reg_wdata,
   output logic [7:0]                 reg_rdata,
   input  wire logic                  device_reset_output,
   input  wire logic                  pin3_strap_high,
   input  wire logic                  interrupt_request_low,
   input  wire logic [PIN_COUNT-1:0]  pin_pad_in,
   output logic [PIN_COUNT-1:0]       pin_pad_out,
   output logic [PIN_COUNT-1:0]       pin_pad_oe,
   output logic [1:0]                 rail_voltage_choice,
   output logic                       sleep_request,
   output logic                       deeper_sleep_request,
   output logic                       rail12_enable_request,
   output logic                       power_off_request,
   output logic                       external_enable_in_one,
   output logic                       external_enable_in_two,
   output logic                       system_monitor_function
);
   localparam logic [7:0] PIN_ADDR [PIN_COUNT] =
      '{ADDR_PIN3, ADDR_PIN4, ADDR_PIN5};

   logic [3:0]                pin_function_select [PIN_COUNT];
   logic [1:0]                pin_output_level    [PIN_COUNT];
   logic                      pin_keep_function   [PIN_COUNT];
   logic                      strap_taken;
   logic [FN_COUNT-1:0]       func_vec [PIN_COUNT];
   logic [7:0]                read_word [PIN_COUNT];
   logic [PIN_COUNT-1:0]      hit;
   logic [PIN_COUNT-1:0]      next_oe;
   logic [PIN_COUNT-1:0]      next_out;
   logic [PIN_COUNT-1:0]      vsel_role;
   logic [FN_COUNT-1:0]       next_func;
   logic [7:0]                next_rdata;

   genvar i;
   generate
      for (i = 0; i < PIN_COUNT; i++) begin : g_pin
         localparam bit HAS_KEEP = (i != PIN5_IDX);
         wire logic wr_hit;
         wire logic strap_load;
         assign hit[i]   = (reg_addr == PIN_ADDR[i]);
         assign wr_hit   = reg_wr_en & hit[i];
         // strap is caught on the first edge after reset release
         assign strap_load = !HAS_KEEP && !strap_taken &&
                             pin3_strap_high && !wr_hit; // RULE8
         // bit 2 and the pin five keep position are not stored
         assign read_word[i] = {HAS_KEEP ? pin_keep_function[i] : 1'b0,
                                pin_function_select[i], 1'b0,
                                pin_output_level[i]}; // RULE12

         always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
               pin_function_select[i] <= HAS_KEEP ? SEL_RESET
                                                  : PIN5_SEL_LOW; // RULE8
               pin_output_level[i]    <= LVL_RESET;
               pin_keep_function[i]   <= KEEP_RESET;
            end else if (wr_hit) begin
               pin_function_select[i] <= reg_wdata[SEL_HI:SEL_LO];
               pin_output_level[i]    <= reg_wdata[LVL_HI:LVL_LO]; // RULE10
               pin_keep_function[i]   <= HAS_KEEP & reg_wdata[KEEP_BIT]; // RULE1
            end else if (strap_load) begin
               pin_function_select[i] <= PIN5_SEL_HIGH; // RULE8
            end
         end

         pfm_pin_slice #(
            .HAS_KEEP    (HAS_KEEP),
            .HAS_MONITOR (!HAS_KEEP)
         ) u_slice (
            .sel            (pin_function_select[i]),
            .level          (pin_output_level[i]),
            .keep           (pin_keep_function[i]),
            .reset_out_high (device_reset_output),
            .pad_in         (pin_pad_in[i]),
            .irq_low        (interrupt_request_low),
            .drive_en       (next_oe[i]),
            .drive_level    (next_out[i]),
            .func_in        (func_vec[i]),
            .vsel_role      (vsel_role[i])
         );
      end
   endgenerate

   assign next_func  = func_vec[0] | func_vec[1] | func_vec[2];
   assign next_rdata = reg_rd_en ? (({8{hit[0]}} & read_word[0]) |
                                    ({8{hit[1]}} & read_word[1]) |
                                    ({8{hit[2]}} & read_word[2]))
                                 : reg_rdata;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         strap_taken <= 1'b0;
      end else begin
         strap_taken <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_pad_oe  <= '0;
         pin_pad_out <= '0;
         reg_rdata   <= RDATA_ZERO;
      end else begin
         pin_pad_oe  <= next_oe; // RULE11
         pin_pad_out <= next_out; // RULE6
         reg_rdata   <= next_rdata;
      end
   end

   // rail choice follows pins three and four until release, then holds
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rail_voltage_choice <= VSEL_RESET;
      end else if (|vsel_role) begin
         rail_voltage_choice <= pin_pad_in[1:0]; // RULE9
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sleep_request           <= 1'b0;
         deeper_sleep_request    <= 1'b0;
         rail12_enable_request   <= 1'b0;
         power_off_request       <= 1'b0;
         external_enable_in_one  <= 1'b0;
         external_enable_in_two  <= 1'b0;
         system_monitor_function <= 1'b0;
      end else begin
         sleep_request           <= next_func[FN_SLEEP]; // RULE3
         deeper_sleep_request    <= next_func[FN_DEEP];
         rail12_enable_request   <= next_func[FN_RAIL12];
         power_off_request       <= next_func[FN_POWER_OFF];
         external_enable_in_one  <= next_func[FN_EXT_IN1]; // RULE4
         external_enable_in_two  <= next_func[FN_EXT_IN2];
         system_monitor_function <= next_func[FN_SYSTEM_MONITOR_FUNCTION]; // RULE5
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   sequence s_pre_release;
      !device_reset_output;
   endsequence
   sequence s_pin3_kept_gen;
      device_reset_output && pin_keep_function[0] &&
      (pin_function_select[0] == FUNC_GEN_OUT1);
   endsequence

   property p_keep_off;
      device_reset_output && !pin_keep_function[0] |=> !pin_pad_oe[0];
   endproperty
   a_keep_off: assert property (p_keep_off) // RULE1
      else $error("pin three drives with keep bit clear");

   property p_no_drive_before_release;
      s_pre_release |=> !pin_pad_oe[0] && !pin_pad_oe[1];
   endproperty
   a_no_drive_before_release: assert property (p_no_drive_before_release) // RULE7
      else $error("pin three or four drives before release");

   property p_gen_level;
      s_pin3_kept_gen |=> pin_pad_oe[0] &&
         (pin_pad_out[0] == ($past(pin_output_level[0]) == LVL_HIGH));
   endproperty
   a_gen_level: assert property (p_gen_level) // RULE6
      else $error("general output level wrong");

   // sampled arst_n masks the release edge, where the flops still hold reset
   property p_irq_follow;
      arst_n && pin_function_select[2] == FUNC_IRQ_OUT |=>
         pin_pad_oe[2] && (pin_pad_out[2] == $past(interrupt_request_low));
   endproperty
   a_irq_follow: assert property (p_irq_follow) // RULE2
      else $error("interrupt pin does not follow request");

   property p_sleep_in;
      pin_function_select[2] == FUNC_SLEEP && pin_pad_in[2] |=>
         sleep_request && !pin_pad_oe[2];
   endproperty
   a_sleep_in: assert property (p_sleep_in) // RULE3
      else $error("sleep input not passed on");

   property p_no_ext_in_low_pins;
      pin_function_select[2] != FUNC_EXT_IN1 |=> !external_enable_in_one;
   endproperty
   a_no_ext_in_low_pins: assert property (p_no_ext_in_low_pins) // RULE4
      else $error("external enable input seen from pin three or four");

   property p_monitor;
      pin_function_select[2] == FUNC_SYSTEM_MONITOR_FUNCTION && pin_pad_in[2] |=>
         system_monitor_function;
   endproperty
   a_monitor: assert property (p_monitor) // RULE5
      else $error("monitor input not passed on");

   property p_strap;
      arst_n && !strap_taken && pin3_strap_high &&
         !(reg_wr_en && hit[2]) |=>
         pin_function_select[2] == PIN5_SEL_HIGH;
   endproperty
   a_strap: assert property (p_strap) // RULE8
      else $error("pin five strap not applied");

   property p_vsel;
      arst_n && !device_reset_output |=>
         rail_voltage_choice == $past(pin_pad_in[1:0]);
   endproperty
   a_vsel: assert property (p_vsel) // RULE9
      else $error("rail choice not sampled before release");

   property p_over_range;
      pin_function_select[2] > FUNC_SYSTEM_MONITOR_FUNCTION |=>
         !pin_pad_oe[2] && !system_monitor_function;
   endproperty
   a_over_range: assert property (p_over_range) // RULE11
      else $error("unused code still active");

   property p_reserved;
      reg_rd_en |=> !reg_rdata[2];
   endproperty
   a_reserved: assert property (p_reserved) // RULE12
      else $error("reserved bit reads nonzero");
endmodule
`default_nettype wire

// File: bench/pfm_host_model.sv
`default_nettype none
module pfm_host_model (
   input  wire logic       ref_clk,
   input  wire logic [2:0] pad_out,
   input  wire logic [2:0] pad_oe,
   input  wire logic [2:0] host_en,
   input  wire logic [2:0] host_lvl,
   output logic      [2:0] pad_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] float_pat = 3'h5;
   // a pad nobody drives wanders, so it never settles at a quiet 0
   always @(posedge ref_clk) float_pat <= ~float_pat;
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & host_en & host_lvl)
                 | (~pad_oe & ~host_en & float_pat);
endmodule
`default_nettype wire

// File: bench/tb_top.sv
`default_nettype none
module tb_top import pfm_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic       ref_clk = 1'b0;
   logic       arst_n = 1'b0;
   logic       wr_en = 1'b0;
   logic       rd_en = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic       rst_out = 1'b0;
   logic       strap = 1'b0;
   logic       irq_n = 1'b1;
   logic [2:0] host_en = 3'h0;
   logic [2:0] host_lvl = 3'h0;
   logic [2:0] pad_in, pad_out, pad_oe;
   logic [1:0] vsel;
   logic [6:0] fv;
   int         err_total = 0;
   int         comparisons = 0;

   always #10 ref_clk = ~ref_clk;

   pfm_top DUT (.ref_clk(ref_clk), .arst_n(arst_n), .reg_wr_en(wr_en),
      .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata),
      .reg_rdata(rdata), .device_reset_output(rst_out),
      .pin3_strap_high(strap), .interrupt_request_low(irq_n),
      .pin_pad_in(pad_in), .pin_pad_out(pad_out), .pin_pad_oe(pad_oe),
      .rail_voltage_choice(vsel), .sleep_request(fv[6]),
      .deeper_sleep_request(fv[5]), .rail12_enable_request(fv[4]),
      .power_off_request(fv[3]), .external_enable_in_one(fv[2]),
      .external_enable_in_two(fv[1]), .system_monitor_function(fv[0]));

   pfm_host_model host (.ref_clk(ref_clk), .pad_out(pad_out),
      .pad_oe(pad_oe), .host_en(host_en), .host_lvl(host_lvl),
      .pad_in(pad_in));

   task automatic chk(input string what, input logic [7:0] e,
                      input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic pchk(input int i, input logic e_oe, input logic e_out);
      chk("pin_pad", {6'h00, e_oe, e_oe & e_out},
          {6'h00, pad_oe[i], pad_oe[i] & pad_out[i]});
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      wr_en <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge ref_clk);
      wr_en <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1 chk("reg_rdata", e, rdata);
   endtask
   task automatic settle();
      repeat (2) @(posedge ref_clk);
      #1;
   endtask
   task automatic do_reset();
      @(posedge ref_clk);
      arst_n <= 1'b0;
      repeat (10) @(posedge ref_clk);
      arst_n <= 1'b1;
   endtask

   task automatic t_regs();
      rd_chk(ADDR_PIN3, 8'h00);
      rd_chk(ADDR_PIN4, 8'h00);
      rd_chk(ADDR_PIN5, 8'h10);
      rd_chk(8'h0A, 8'h00);
      pchk(2, 1'b1, 1'b1);
      @(posedge ref_clk);
      strap <= 1'b1;
      do_reset();
      rd_chk(ADDR_PIN5, 8'h18);
      wr(ADDR_PIN3, 8'hFF);
      rd_chk(ADDR_PIN3, 8'hFB);
      wr(ADDR_PIN5, 8'hFF);
      rd_chk(ADDR_PIN5, 8'h7B);
      wr(8'h0A, 8'h55);
      rd_chk(8'h0A, 8'h00);
      @(posedge ref_clk);
      strap <= 1'b0;
      do_reset();
      $display("test regs done");
   endtask
   task automatic t_keep();
      host_en <= 3'h3;
      host_lvl <= 3'h1;
      wr(ADDR_PIN3, 8'h80);
      settle();
      pchk(0, 1'b0, 1'b0);
      chk("vsel", 8'h01, {6'h00, vsel});
      @(posedge ref_clk);
      host_en <= 3'h0;
      rst_out <= 1'b1;
      settle();
      pchk(0, 1'b1, 1'b0);
      wr(ADDR_PIN3, 8'h81);
      settle();
      pchk(0, 1'b1, 1'b1);
      wr(ADDR_PIN3, 8'h01);
      settle();
      pchk(0, 1'b0, 1'b0);
      chk("vsel", 8'h01, {6'h00, vsel});
      $display("test keep done");
   endtask
   task automatic t_outs();
      @(posedge ref_clk);
      irq_n <= 1'b0;
      for (int c = 0; c < 3; c++) begin
         wr(ADDR_PIN4, {1'b1, 4'(c), 3'h1});
         settle();
         pchk(1, 1'b1, c != 2);
      end
      @(posedge ref_clk);
      irq_n <= 1'b1;
      settle();
      pchk(1, 1'b1, 1'b1);
      $display("test outputs done");
   endtask
   task automatic t_ins();
      @(posedge ref_clk);
      host_en <= 3'h4;
      host_lvl <= 3'h4;
      for (int c = 3; c < 10; c++) begin
         wr(ADDR_PIN5, {1'b0, 4'(c), 3'h0});
         settle();
         chk("func_in", {1'b0, 7'h40 >> (c - 3)}, {1'b0, fv});
         pchk(2, 1'b0, 1'b0);
      end
      $display("test inputs done");
   endtask
   task automatic t_refuse();
      wr(ADDR_PIN3, 8'hB8);
      wr(ADDR_PIN5, 8'h50);
      host_en <= 3'h5;
      host_lvl <= 3'h5;
      settle();
      chk("func_in", 8'h00, {1'b0, fv});
      pchk(2, 1'b0, 1'b0);
      pchk(1, 1'b1, 1'b1);
      $display("test refuse done");
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial begin
      repeat (10) @(posedge ref_clk);
      arst_n <= 1'b1;
      t_regs();
      t_keep();
      t_outs();
      t_ins();
      t_refuse();
      report_and_stop();
   end
   initial begin
      #100us;
      err_total++;
      report_and_stop();
   end
endmodule
`default_nettype wire
